// File: dv/mmpd_cpu_model.sv
`timescale 1ns/1ps

module mmpd_cpu_model (
    input  wire logic                mclk,
    input  wire mmpd_pkg::mmpd_sel_t mem_sel,
    output mmpd_pkg::mmpd_req_t      cpu_req
);
    import mmpd_pkg::*;
    initial cpu_req = '0;
    // One request cycle, then the address lines are released to their inverse.
    task automatic access(input mmpd_mode_t m, input logic [15:0] ad, output mmpd_sel_t s);
        @(posedge mclk);
        cpu_req <= '{1'b1, m, ad};
        @(posedge mclk);
        cpu_req <= '{1'b0, mmpd_mode_t'(~m), ~ad};
        #1;
        s = mem_sel;
    endtask
endmodule

// File: dv/mmpd_decoder_chk.sv
`timescale 1ns/1ps

module mmpd_decoder_chk (
    input wire logic                mclk,
    input wire logic                rst_b,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic                avs_waitrequest,
    input wire mmpd_pkg::mmpd_req_t cpu_req,
    input wire mmpd_pkg::mmpd_sel_t mem_sel
);
    import mmpd_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire        lcl = cpu_req.valid && cpu_req.mode == MMPD_MODE_LOCAL;
    wire [15:0] a   = cpu_req.addr;
    sequence s_wait; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_ack; (avs_read || avs_write) && !avs_waitrequest; endsequence
    a_bus_one_wait: assert property (s_wait |=> s_ack) else $error("No answer after one wait state.");
    a_reg_map: assert property (lcl && a <= MMPD_REG_LAST |=>
        mem_sel == {1'b1, MMPD_TGT_REG, 12'h000, $past(a[10:0])}) else $error("Register decode wrong.");
    a_ee_window: assert property (lcl && a[15:10] == 6'h02 |=> mem_sel.target == MMPD_TGT_EE &&
        mem_sel.phys[22:12] == 11'h000 && mem_sel.phys[9:0] == $past(a[9:0])) else $error("EEPROM window wrong.");
    a_ee_fixed: assert property (lcl && a[15:10] == 6'h03 |=>
        mem_sel.phys == {11'h000, MMPD_EE_FIXED_PAGE, $past(a[9:0])}) else $error("Fixed EEPROM wrong.");
    a_ram_window: assert property (lcl && a[15:12] == 4'h1 |=> mem_sel.target == MMPD_TGT_RAM &&
        mem_sel.phys[22:15] == 8'h00 && mem_sel.phys[11:0] == $past(a[11:0])) else $error("RAM window wrong.");
    a_ram_fixed: assert property (lcl && a[15:13] == 3'h1 |=>
        mem_sel == {1'b1, MMPD_TGT_RAM, 8'h00, 2'h3, $past(a[12:0])}) else $error("Fixed RAM wrong.");
    a_flash_win: assert property (lcl && a[15:14] != 2'h0 |=> mem_sel ==
        {1'b1, MMPD_TGT_FLASH, 7'h00, $past(a[15:14]) - 2'h1, $past(a[13:0])}) else $error("FLASH decode wrong.");
    a_global_blk: assert property (cpu_req.valid && cpu_req.mode == MMPD_MODE_GLOBAL |=>
        mem_sel.target == MMPD_TGT_GLOBAL && mem_sel.phys[15:0] == $past(a)) else $error("Global decode wrong.");
    a_direct_low: assert property (cpu_req.valid && cpu_req.mode == MMPD_MODE_DIRECT |=>
        mem_sel.valid && mem_sel.phys[7:0] == $past(a[7:0])) else $error("Direct decode wrong.");
    a_idle_zero: assert property (!cpu_req.valid |=> mem_sel == '0) else $error("Idle select not cleared.");
endmodule

bind mmpd_decoder mmpd_decoder_chk u_chk (.mclk, .rst_b, .avs_read, .avs_write, .avs_waitrequest, .cpu_req, .mem_sel);

// File: dv/mmpd_decoder_tb.sv
`timescale 1ns/1ps

module mmpd_decoder_tb;
    import mmpd_pkg::*;
    logic        mclk, rst_b, avs_read, avs_write, avs_waitrequest;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable;
    mmpd_req_t   cpu_req;
    mmpd_sel_t   mem_sel, s;
    int          n_errors = 0;
    int          total_checks = 0;
    localparam mmpd_mode_t L = MMPD_MODE_LOCAL;
    mmpd_decoder uut (.mclk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_req, .mem_sel);
    mmpd_cpu_model cpu (.mclk, .mem_sel, .cpu_req);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Avalon transfer; the request stands until the rising edge at which waitrequest is sampled low.
    // Read data is taken at that same edge, and only then is the request released.
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= ad;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge mclk);
            n++;
            if (n > 20) begin
                n_errors++;
                final_report();
            end
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic sel(input mmpd_mode_t m, input logic [15:0] ad, input mmpd_target_t t, input logic [22:0] p);
        cpu.access(m, ad, s);
        check(s, {1'b1, t, p});
    endtask
    initial begin
        rst_b = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0, 4'hF);
            check(q, 32'h0);
        end
        sel(L, 16'h0000, MMPD_TGT_REG, 23'h000000);
        sel(L, 16'h07FF, MMPD_TGT_REG, 23'h0007FF);
        sel(L, 16'h0805, MMPD_TGT_EE, 23'h000005);
        sel(L, 16'h0FFF, MMPD_TGT_EE, 23'h000FFF);
        sel(L, 16'h1000, MMPD_TGT_RAM, 23'h000000);
        sel(L, 16'h3FFF, MMPD_TGT_RAM, 23'h007FFF);
        sel(L, 16'h4000, MMPD_TGT_FLASH, 23'h000000);
        sel(L, 16'hBFFF, MMPD_TGT_FLASH, 23'h007FFF);
        sel(L, 16'hFFFF, MMPD_TGT_FLASH, 23'h00BFFF);
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, MMPD_OFF_EE_PAGE, 32'hA5A5A500 | p, 4'hF);
            bus(1'b0, MMPD_OFF_EE_PAGE, 32'h0, 4'hF);
            check(q, p);
            sel(L, 16'h0BFF, MMPD_TGT_EE, {11'h0, p[1:0], 10'h3FF});
            sel(L, 16'h0C01, MMPD_TGT_EE, 23'h000C01);
        end
        for (int p = 0; p < 8; p++) begin
            bus(1'b1, MMPD_OFF_RAM_PAGE, p, 4'hF);
            sel(L, 16'h1ABC, MMPD_TGT_RAM, {8'h0, p[2:0], 12'hABC});
            sel(L, 16'h2000, MMPD_TGT_RAM, 23'h006000);
        end
        bus(1'b1, MMPD_OFF_RAM_PAGE, 32'h2, 4'h0);
        bus(1'b0, MMPD_OFF_RAM_PAGE, 32'h0, 4'hF);
        check(q, 32'h7);
        bus(1'b1, MMPD_OFF_GLB_PAGE, 32'h55, 4'hF);
        sel(MMPD_MODE_GLOBAL, 16'h1234, MMPD_TGT_GLOBAL, {7'h55, 16'h1234});
        sel(L, 16'h1234, MMPD_TGT_RAM, 23'h007234);
        bus(1'b1, MMPD_OFF_DIR_PAGE, 32'h3C, 4'hF);
        sel(MMPD_MODE_DIRECT, 16'h0012, MMPD_TGT_RAM, 23'h007C12);
        bus(1'b1, MMPD_OFF_DIR_PAGE, 32'h0, 4'hF);
        sel(MMPD_MODE_DIRECT, 16'hFF05, MMPD_TGT_REG, 23'h000005);
        bus(1'b0, MMPD_OFF_LAST_TGT, 32'h0, 4'hF);
        check(q, 32'(MMPD_TGT_REG));
        bus(1'b0, MMPD_OFF_LAST_PHY, 32'h0, 4'hF);
        check(q, 32'h5);
        bus(1'b1, 8'h18, 32'hFF, 4'hF);
        bus(1'b0, 8'h18, 32'h0, 4'hF);
        check(q, 32'h0);
        sel(L, 16'h0805, MMPD_TGT_EE, 23'h000C05);
        final_report();
    end
endmodule

// File: hw/mmpd_decoder.sv
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps

module mmpd_decoder (
    input  wire logic                mclk,
    input  wire logic                rst_b,
    input  wire logic [7:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    input  wire mmpd_pkg::mmpd_req_t cpu_req,
    output mmpd_pkg::mmpd_sel_t      mem_sel
);
    import mmpd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus slave with one wait state.

    logic              ack_q;
    logic              bus_wr;
    logic              bus_rd;
    logic [31:0]       rdata_d;
    logic [31:0]       rdata_q;
    mmpd_pages_t       pages_q;
    mmpd_target_t      last_tgt_q;
    logic [MMPD_PHYS_W-1:0] last_phys_q;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign bus_wr          = avs_write & ~avs_waitrequest;
    assign bus_rd          = avs_read & ~avs_waitrequest;
    assign avs_readdata    = rdata_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (avs_address)
            MMPD_OFF_EE_PAGE:  rdata_d = {30'h0, pages_q.ee};
            MMPD_OFF_RAM_PAGE: rdata_d = {29'h0, pages_q.ram};
            MMPD_OFF_GLB_PAGE: rdata_d = {25'h0, pages_q.glb};
            MMPD_OFF_DIR_PAGE: rdata_d = {24'h0, pages_q.dir};
            MMPD_OFF_LAST_TGT: rdata_d = {29'h0, last_tgt_q};
            MMPD_OFF_LAST_PHY: rdata_d = {9'h000, last_phys_q};
            default:           rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data is loaded in the wait cycle so it stands at the edge where waitrequest is low.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read & avs_waitrequest) begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Page registers; widths below 32 bits drop the upper written bits.

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pages_q.ee  <= MMPD_EE_PAGE_RST;
            pages_q.ram <= MMPD_RAM_PAGE_RST;
            pages_q.glb <= MMPD_GLB_PAGE_RST;
            pages_q.dir <= MMPD_DIR_PAGE_RST;
        end else if (bus_wr && avs_byteenable[0]) begin
            unique case (avs_address)
                MMPD_OFF_EE_PAGE:  pages_q.ee  <= avs_writedata[MMPD_EE_PAGE_W-1:0];
                MMPD_OFF_RAM_PAGE: pages_q.ram <= avs_writedata[MMPD_RAM_PAGE_W-1:0];
                MMPD_OFF_GLB_PAGE: pages_q.glb <= avs_writedata[MMPD_GLB_PAGE_W-1:0];
                MMPD_OFF_DIR_PAGE: pages_q.dir <= avs_writedata[MMPD_DIR_PAGE_W-1:0];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // CPU access decode.

    logic [15:0]            local_addr;
    mmpd_target_t           local_tgt;
    logic [MMPD_PHYS_W-1:0] local_phys;
    mmpd_sel_t              sel_d;
    mmpd_sel_t              sel_q;

    always_comb begin
        local_addr = cpu_req.addr;
        if (cpu_req.mode == MMPD_MODE_DIRECT) begin
            local_addr = {pages_q.dir, cpu_req.addr[7:0]};
        end
    end

    mmpd_local_map u_local_map (
        .addr   (local_addr),
        .pages  (pages_q),
        .target (local_tgt),
        .phys   (local_phys)
    );

    always_comb begin
        sel_d.valid  = cpu_req.valid;
        sel_d.target = local_tgt;
        sel_d.phys   = local_phys;
        if (cpu_req.mode == MMPD_MODE_GLOBAL) begin
            sel_d.target = MMPD_TGT_GLOBAL;
            sel_d.phys   = {pages_q.glb, cpu_req.addr};
        end
        if (!cpu_req.valid) begin
            sel_d.target = MMPD_TGT_NONE;
            sel_d.phys   = '0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sel_q <= '0;
        end else begin
            sel_q <= sel_d;
        end
    end

    assign mem_sel = sel_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            last_tgt_q  <= MMPD_TGT_NONE;
            last_phys_q <= '0;
        end else if (cpu_req.valid) begin
            last_tgt_q  <= sel_d.target;
            last_phys_q <= sel_d.phys;
        end
    end

endmodule

// File: hw/mmpd_local_map.sv
`timescale 1ns/1ps

module mmpd_local_map (
    input  wire logic [15:0]                   addr,
    input  wire mmpd_pkg::mmpd_pages_t         pages,
    output mmpd_pkg::mmpd_target_t             target,
    output logic [mmpd_pkg::MMPD_PHYS_W-1:0]   phys
);
    import mmpd_pkg::*;

    always_comb begin
        target = MMPD_TGT_NONE;
        phys   = '0;
        if (addr <= MMPD_REG_LAST) begin
            target = MMPD_TGT_REG;
            phys   = {12'h000, addr[MMPD_REG_OFF_W-1:0]};
        end else if (addr < MMPD_EE_FIXED) begin
            target = MMPD_TGT_EE;
            phys   = {11'h000, pages.ee, addr[MMPD_EE_OFF_W-1:0]};
        end else if (addr < MMPD_RAM_BASE) begin
            target = MMPD_TGT_EE;
            phys   = {11'h000, MMPD_EE_FIXED_PAGE, addr[MMPD_EE_OFF_W-1:0]};
        end else if (addr < MMPD_RAM_FIXED) begin
            target = MMPD_TGT_RAM;
            phys   = {8'h00, pages.ram, addr[MMPD_RAM_OFF_W-1:0]};
        end else if (addr < MMPD_FLASH_BASE) begin
            target = MMPD_TGT_RAM;
            phys   = {8'h00, MMPD_RAM_FIXED_HI, addr[MMPD_RAM_FIX_W-1:0]};
        end else begin
            target = MMPD_TGT_FLASH;
            phys   = {7'h00, 2'(addr[15:14] - MMPD_FLASH_WIN0), addr[MMPD_FLASH_OFF_W-1:0]};
        end
    end

endmodule

// File: hw/mmpd_pkg.sv
package mmpd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Local map boundaries.
    localparam logic [15:0] MMPD_REG_LAST    = 16'h07FF;
    localparam logic [15:0] MMPD_EE_BASE     = 16'h0800;
    localparam logic [15:0] MMPD_EE_FIXED    = 16'h0C00;
    localparam logic [15:0] MMPD_RAM_BASE    = 16'h1000;
    localparam logic [15:0] MMPD_RAM_FIXED   = 16'h2000;
    localparam logic [15:0] MMPD_FLASH_BASE  = 16'h4000;

    ////////////////////////////////////////////////////////////////////////////////
    // Page widths and physical widths.
    localparam int MMPD_EE_PAGE_W   = 2;
    localparam int MMPD_RAM_PAGE_W  = 3;
    localparam int MMPD_GLB_PAGE_W  = 7;
    localparam int MMPD_DIR_PAGE_W  = 8;
    localparam int MMPD_PHYS_W      = 23;
    localparam int MMPD_EE_OFF_W    = 10;
    localparam int MMPD_RAM_OFF_W   = 12;
    localparam int MMPD_RAM_FIX_W   = 13;
    localparam int MMPD_REG_OFF_W   = 11;
    localparam int MMPD_FLASH_OFF_W = 14;

    // The fixed EEPROM block is the top 1 Kbyte page, the fixed RAM area the top two 4 Kbyte blocks.
    localparam logic [1:0] MMPD_EE_FIXED_PAGE = 2'h3;
    localparam logic [1:0] MMPD_RAM_FIXED_HI  = 2'h3;
    localparam logic [1:0] MMPD_FLASH_WIN0    = 2'h1;

    ////////////////////////////////////////////////////////////////////////////////
    // Register file.
    localparam logic [7:0] MMPD_OFF_EE_PAGE  = 8'h00;
    localparam logic [7:0] MMPD_OFF_RAM_PAGE = 8'h04;
    localparam logic [7:0] MMPD_OFF_GLB_PAGE = 8'h08;
    localparam logic [7:0] MMPD_OFF_DIR_PAGE = 8'h0C;
    localparam logic [7:0] MMPD_OFF_LAST_TGT = 8'h10;
    localparam logic [7:0] MMPD_OFF_LAST_PHY = 8'h14;

    localparam logic [MMPD_EE_PAGE_W-1:0]  MMPD_EE_PAGE_RST  = 2'h0;
    localparam logic [MMPD_RAM_PAGE_W-1:0] MMPD_RAM_PAGE_RST = 3'h0;
    localparam logic [MMPD_GLB_PAGE_W-1:0] MMPD_GLB_PAGE_RST = 7'h00;
    localparam logic [MMPD_DIR_PAGE_W-1:0] MMPD_DIR_PAGE_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [2:0] {
        MMPD_TGT_NONE   = 3'h0,
        MMPD_TGT_REG    = 3'h1,
        MMPD_TGT_EE     = 3'h3,
        MMPD_TGT_RAM    = 3'h2,
        MMPD_TGT_FLASH  = 3'h6,
        MMPD_TGT_GLOBAL = 3'h7
    } mmpd_target_t;

    typedef enum logic [1:0] {
        MMPD_MODE_LOCAL  = 2'h0,
        MMPD_MODE_DIRECT = 2'h1,
        MMPD_MODE_GLOBAL = 2'h3
    } mmpd_mode_t;

    typedef struct packed {
        logic        valid;
        mmpd_mode_t  mode;
        logic [15:0] addr;
    } mmpd_req_t;

    typedef struct packed {
        logic                   valid;
        mmpd_target_t           target;
        logic [MMPD_PHYS_W-1:0] phys;
    } mmpd_sel_t;

    typedef struct packed {
        logic [MMPD_EE_PAGE_W-1:0]  ee;
        logic [MMPD_RAM_PAGE_W-1:0] ram;
        logic [MMPD_GLB_PAGE_W-1:0] glb;
        logic [MMPD_DIR_PAGE_W-1:0] dir;
    } mmpd_pages_t;

endpackage
